/* common/mdua_consts.vh */
// register offsets, field positions, reset values and timing figures of the management access engine
`ifndef MDUA_CONSTS_VH
`define MDUA_CONSTS_VH

// register byte offsets
`define MDUA_OFF_CONTROL     8'h00
`define MDUA_OFF_ALIVE       8'h04
`define MDUA_OFF_LINK        8'h08
`define MDUA_OFF_LINK_CHG    8'h0C
`define MDUA_OFF_DONE_RAW    8'h14
`define MDUA_OFF_DONE_MASKED 8'h18
`define MDUA_OFF_MASK_SET    8'h1C
`define MDUA_OFF_MASK_CLEAR  8'h20
`define MDUA_OFF_ACCESS0     8'h24
`define MDUA_OFF_ACCESS1     8'h2C
`define MDUA_OFF_SELECT0     8'h28
`define MDUA_CH_STRIDE       8'h08

// control register fields
`define MDUA_CTL_IDLE        31
`define MDUA_CTL_ENABLE      30
`define MDUA_CTL_PRE_OFF     20
`define MDUA_CTL_DIV_HI      15
`define MDUA_CTL_DIV_LO      0

// access request fields
`define MDUA_ACC_GO          31
`define MDUA_ACC_WRITE       30
`define MDUA_ACC_ACK         29
`define MDUA_ACC_REG_HI      25
`define MDUA_ACC_REG_LO      21
`define MDUA_ACC_PHY_HI      20
`define MDUA_ACC_PHY_LO      16

// monitored select fields
`define MDUA_SEL_IRQ_EN      7

// reset values
`define MDUA_DIV_RST         16'h00FF
`define MDUA_PRE_OFF_RST     1'b0

// polled status register and its link bit
`define MDUA_POLL_REG        5'h01
`define MDUA_POLL_LINK_BIT   2

// frame geometry, bit positions counted from the first preamble bit
`define MDUA_PRE_BITS        6'd32
`define MDUA_TA_LAST         6'd47
`define MDUA_DATA_FIRST      6'd48
`define MDUA_FRAME_LAST      6'd63
`define MDUA_DRIVE_LAST_RD   6'd45

// timing: highest management clock in kHz and the clock rate in kHz
`define MDUA_MDC_MAX_KHZ     2500
`define MDUA_PCLK_KHZ        100000

`endif

/* rtl/mdua_frame.v */
// serial management frame engine with its own clock divider
`timescale 1ns/1ps
`default_nettype none
`include "mdua_consts.vh"

module mdua_frame (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        enable,
    input  wire [15:0] clk_div,
    input  wire        pre_en,
    input  wire        start,
    input  wire        is_write,
    input  wire [4:0]  phy_addr,
    input  wire [4:0]  reg_idx,
    input  wire [15:0] wdata,
    input  wire        mdio_s,
    output reg         busy,
    output reg         done,
    output reg         ack,
    output reg  [15:0] rdata,
    output reg         mdc,
    output reg         mdio_o,
    output reg         mdio_oe
);

    reg  [15:0] div_cnt_r;
    reg  [5:0]  idx_r;
    reg         primed_r;
    reg         wr_r;
    reg  [63:0] frame_r;
    reg         sync1_r, sync2_r;
    wire [15:0] half_w = {1'b0, clk_div[15:1]};
    wire        fall_w = enable && (div_cnt_r == 16'h0000);
    wire        rise_w = enable && (div_cnt_r == half_w);
    wire [5:0]  idx_inc_w = idx_r + 6'd1;

    // management clock period is clk_div plus one pclk cycles
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            div_cnt_r <= 16'h0000;
        else if (!enable || div_cnt_r >= clk_div)
            div_cnt_r <= 16'h0000;
        else
            div_cnt_r <= div_cnt_r + 16'h0001;
    end

    // clock pin: low on fall tick, high on rise tick
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            mdc <= 1'b0;
        else if (fall_w)
            mdc <= 1'b0;
        else if (rise_w)
            mdc <= 1'b1;
    end

    // shift the frame out on falling ticks, released during read turnaround
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            busy     <= 1'b0;
            done     <= 1'b0;
            idx_r    <= 6'd0;
            primed_r <= 1'b0;
            wr_r     <= 1'b0;
            frame_r  <= 64'h0000_0000_0000_0000;
            mdio_o   <= 1'b1;
            mdio_oe  <= 1'b0;
        end
        else
        begin
            done <= 1'b0;
            if (start && !busy)
            begin
                busy     <= 1'b1;
                primed_r <= 1'b0;
                wr_r     <= is_write;
                idx_r    <= pre_en ? 6'd0 : `MDUA_PRE_BITS;
                // preamble, start, opcode, address, index, turnaround, data
                frame_r  <= {32'hFFFF_FFFF, 2'b01, (is_write ? 2'b01 : 2'b10), phy_addr, reg_idx,
                             (is_write ? 2'b10 : 2'b11), (is_write ? wdata : 16'hFFFF)};
            end
            else if (busy && fall_w)
            begin
                if (!primed_r)
                begin
                    primed_r <= 1'b1;
                    mdio_o   <= frame_r[6'd63 - idx_r];
                    mdio_oe  <= 1'b1;
                end
                else if (idx_r == `MDUA_FRAME_LAST)
                begin
                    busy    <= 1'b0;
                    done    <= 1'b1;
                    mdio_o  <= 1'b1;
                    mdio_oe <= 1'b0;
                end
                else
                begin
                    idx_r   <= idx_inc_w;
                    mdio_o  <= frame_r[6'd63 - idx_inc_w];
                    mdio_oe <= wr_r || (idx_inc_w <= `MDUA_DRIVE_LAST_RD);
                end
            end
        end
    end

    // two flops on the serial pin before anyone looks at it; idles at the pull-up level
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sync1_r <= 1'b1;
            sync2_r <= 1'b1;
        end
        else
        begin
            sync1_r <= mdio_s;
            sync2_r <= sync1_r;
        end
    end

    // sample the phy on rising ticks: turnaround low means acknowledged
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ack   <= 1'b0;
            rdata <= 16'h0000;
        end
        else if (busy && primed_r && rise_w && !wr_r)
        begin
            if (idx_r == `MDUA_TA_LAST)
                ack <= !sync2_r;
            else if (idx_r >= `MDUA_DATA_FIRST)
                rdata <= {rdata[14:0], sync2_r};
        end
        else if (start && !busy)
            ack <= 1'b0;
    end

endmodule // mdua_frame
`default_nettype wire

/* rtl/mdua_top.v */
// management access engine: apb registers, request arbitration and phy polling
`timescale 1ns/1ps
`default_nettype none
`include "mdua_consts.vh"

module mdua_top #(
    parameter NCH = 2
) (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    output wire        mdc,
    output wire        mdio_o,
    output wire        mdio_oe,
    input  wire        mdio_i,
    output reg         done_irq,
    output reg         link_irq
);

    // smallest divider keeping the clock at or below its ceiling
    localparam integer DIV_MIN = (`MDUA_PCLK_KHZ + `MDUA_MDC_MAX_KHZ - 1) / `MDUA_MDC_MAX_KHZ - 1;

    localparam [1:0] OWN_NONE = 2'd0;
    localparam [1:0] OWN_USER = 2'd1;
    localparam [1:0] OWN_POLL = 2'd2;

    reg         enable_r, pre_off_r;
    reg  [15:0] div_r, fr_data_r;
    reg  [31:0] alive_r, link_r;
    reg  [1:0]  mask_r, owner_r;
    reg         owner_ch_r, rr_r, start_r, fr_wr_r;
    reg  [4:0]  poll_addr_r, fr_phy_r, fr_reg_r;
    reg  [31:0] rd_nxt;
    reg         err_nxt;
    wire        eng_busy, eng_done, eng_ack;
    wire [15:0] eng_rdata;

    wire [NCH-1:0] go_w, wr_w, ackb_w, sel_en_w, raw_w, lchg_w;
    wire [4:0]     reg_w [0:NCH-1], phy_w [0:NCH-1], sel_phy_w [0:NCH-1];
    wire [15:0]    data_w [0:NCH-1];

    // apb write strobe, taken only on the access cycle
    wire        wr_en = psel && penable && pready && pwrite;
    wire        ch_done = eng_done && (owner_r == OWN_USER);
    wire        poll_done = eng_done && (owner_r == OWN_POLL);
    wire [4:0]  done_phy = fr_phy_r;
    wire        new_link = eng_ack && eng_rdata[`MDUA_POLL_LINK_BIT];

    // control register; a divider below the ceiling is raised to keep the pin legal
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            enable_r  <= 1'b0;
            pre_off_r <= `MDUA_PRE_OFF_RST;
            div_r     <= `MDUA_DIV_RST;
            mask_r    <= 2'b00;
        end
        else if (wr_en)
        begin
            if (paddr == `MDUA_OFF_CONTROL)
            begin
                enable_r  <= pwdata[`MDUA_CTL_ENABLE];
                pre_off_r <= pwdata[`MDUA_CTL_PRE_OFF];
                div_r     <= (pwdata[15:0] < DIV_MIN[15:0]) ? DIV_MIN[15:0] : pwdata[15:0];
            end
            if (paddr == `MDUA_OFF_MASK_SET)
                mask_r <= mask_r | pwdata[1:0];
            if (paddr == `MDUA_OFF_MASK_CLEAR)
                mask_r <= mask_r & ~pwdata[1:0];
        end
    end

    // per request register: access fields, monitored select, completion and link flags
    genvar n;
    generate
        for (n = 0; n < NCH; n = n + 1)
        begin : g_ch
            localparam integer ACC_OFF = `MDUA_OFF_ACCESS0 + n * `MDUA_CH_STRIDE;
            localparam integer SEL_OFF = `MDUA_OFF_SELECT0 + n * `MDUA_CH_STRIDE;
            reg        go_r, wr_r, ack_r, sel_en_r, raw_r, lchg_r;
            reg [4:0]  reg_r, phy_r, sel_phy_r;
            reg [15:0] data_r;
            wire       mine = ch_done && (owner_ch_r == n);
            wire       lchg_set = poll_done && sel_en_r && (done_phy == sel_phy_r) &&
                                  (new_link != link_r[done_phy]);

            // a running request locks its register against new writes
            always @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                begin
                    go_r   <= 1'b0;
                    wr_r   <= 1'b0;
                    ack_r  <= 1'b0;
                    reg_r  <= 5'h00;
                    phy_r  <= 5'h00;
                    data_r <= 16'h0000;
                end
                else if (mine)
                begin
                    go_r <= 1'b0;
                    if (!wr_r)
                    begin
                        data_r <= eng_rdata;
                        ack_r  <= eng_ack;
                    end
                end
                else if (wr_en && paddr == ACC_OFF[7:0] && !go_r)
                begin
                    go_r   <= pwdata[`MDUA_ACC_GO];
                    wr_r   <= pwdata[`MDUA_ACC_WRITE];
                    ack_r  <= 1'b0;
                    reg_r  <= pwdata[`MDUA_ACC_REG_HI:`MDUA_ACC_REG_LO];
                    phy_r  <= pwdata[`MDUA_ACC_PHY_HI:`MDUA_ACC_PHY_LO];
                    data_r <= pwdata[15:0];
                end
            end

            // select register and sticky flags; a set in the clearing cycle wins
            always @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                begin
                    sel_phy_r <= 5'h00;
                    sel_en_r  <= 1'b0;
                    raw_r     <= 1'b0;
                    lchg_r    <= 1'b0;
                end
                else
                begin
                    if (wr_en && paddr == SEL_OFF[7:0])
                    begin
                        sel_phy_r <= pwdata[4:0];
                        sel_en_r  <= pwdata[`MDUA_SEL_IRQ_EN];
                    end
                    raw_r  <= mine ||
                              (raw_r && !(wr_en && paddr == `MDUA_OFF_DONE_RAW && pwdata[n]));
                    lchg_r <= lchg_set ||
                              (lchg_r && !(wr_en && paddr == `MDUA_OFF_LINK_CHG && pwdata[n]));
                end
            end

            assign go_w[n]      = go_r;
            assign wr_w[n]      = wr_r;
            assign ackb_w[n]    = ack_r;
            assign reg_w[n]     = reg_r;
            assign phy_w[n]     = phy_r;
            assign data_w[n]    = data_r;
            assign sel_phy_w[n] = sel_phy_r;
            assign sel_en_w[n]  = sel_en_r;
            assign raw_w[n]     = raw_r;
            assign lchg_w[n]    = lchg_r;
        end
    endgenerate

    // scheduler: user requests first in round robin, otherwise the next poll address
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            owner_r     <= OWN_NONE;
            owner_ch_r  <= 1'b0;
            rr_r        <= 1'b0;
            poll_addr_r <= 5'h00;
            start_r     <= 1'b0;
            fr_wr_r     <= 1'b0;
            fr_phy_r    <= 5'h00;
            fr_reg_r    <= 5'h00;
            fr_data_r   <= 16'h0000;
        end
        else
        begin
            start_r <= 1'b0;
            case (owner_r)
                OWN_NONE:
                begin
                    if (enable_r && !eng_busy && !start_r)
                    begin
                        start_r <= 1'b1;
                        if (go_w[0] || go_w[1])
                        begin
                            // round robin: rr_r names the favoured register
                            owner_r    <= OWN_USER;
                            owner_ch_r <= (go_w[0] && go_w[1]) ? rr_r : go_w[1];
                            rr_r       <= (go_w[0] && go_w[1]) ? ~rr_r : ~go_w[1];
                            fr_wr_r    <= wr_w[(go_w[0] && go_w[1]) ? rr_r : go_w[1]];
                            fr_phy_r   <= phy_w[(go_w[0] && go_w[1]) ? rr_r : go_w[1]];
                            fr_reg_r   <= reg_w[(go_w[0] && go_w[1]) ? rr_r : go_w[1]];
                            fr_data_r  <= data_w[(go_w[0] && go_w[1]) ? rr_r : go_w[1]];
                        end
                        else
                        begin
                            owner_r   <= OWN_POLL;
                            fr_wr_r   <= 1'b0;
                            fr_phy_r  <= poll_addr_r;
                            fr_reg_r  <= `MDUA_POLL_REG;
                            fr_data_r <= 16'h0000;
                        end
                    end
                end
                OWN_USER, OWN_POLL:
                begin
                    if (eng_done)
                    begin
                        owner_r <= OWN_NONE;
                        if (owner_r == OWN_POLL)
                            poll_addr_r <= poll_addr_r + 5'h01;
                    end
                end
                default:
                    owner_r <= OWN_NONE;
            endcase
        end
    end

    // presence and link tables, both updated by polls; presence also by user reads
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            alive_r <= 32'h0000_0000;
            link_r  <= 32'h0000_0000;
        end
        else if (poll_done)
        begin
            alive_r[done_phy] <= eng_ack;
            link_r[done_phy]  <= new_link;
        end
        else if (ch_done && !fr_wr_r)
            alive_r[done_phy] <= eng_ack;
    end

    // interrupt outputs from flops
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            done_irq <= 1'b0;
            link_irq <= 1'b0;
        end
        else
        begin
            done_irq <= |(raw_w & mask_r);
            link_irq <= |lchg_w;
        end
    end

    // read mux; unmapped addresses answer with an error and zero data
    always @*
    begin
        rd_nxt  = 32'h0000_0000;
        err_nxt = 1'b0;
        case (paddr)
            `MDUA_OFF_CONTROL:     rd_nxt = {!eng_busy, enable_r, 9'h000, pre_off_r, 4'h0, div_r};
            `MDUA_OFF_ALIVE:       rd_nxt = alive_r;
            `MDUA_OFF_LINK:        rd_nxt = link_r;
            `MDUA_OFF_LINK_CHG:    rd_nxt = {30'h0000_0000, lchg_w};
            `MDUA_OFF_DONE_RAW:    rd_nxt = {30'h0000_0000, raw_w};
            `MDUA_OFF_DONE_MASKED: rd_nxt = {30'h0000_0000, raw_w & mask_r};
            `MDUA_OFF_MASK_SET:    rd_nxt = {30'h0000_0000, mask_r};
            `MDUA_OFF_MASK_CLEAR:  rd_nxt = {30'h0000_0000, mask_r};
            8'h24:                 rd_nxt = {go_w[0], wr_w[0], ackb_w[0], 3'b000, reg_w[0], phy_w[0], data_w[0]};
            8'h28:                 rd_nxt = {24'h00_0000, sel_en_w[0], 2'b00, sel_phy_w[0]};
            8'h2C:                 rd_nxt = {go_w[1], wr_w[1], ackb_w[1], 3'b000, reg_w[1], phy_w[1], data_w[1]};
            8'h30:                 rd_nxt = {24'h00_0000, sel_en_w[1], 2'b00, sel_phy_w[1]};
            default:               err_nxt = 1'b1;
        endcase
    end

    // apb answer: ready on the first access cycle, no wait states
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end
        else
        begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && err_nxt;
            prdata  <= (psel && !penable && !pwrite) ? rd_nxt : 32'h0000_0000;
        end
    end

    mdua_frame u_frame (
        .pclk     (pclk),
        .presetn  (presetn),
        .enable   (enable_r),
        .clk_div  (div_r),
        .pre_en   (!pre_off_r),
        .start    (start_r),
        .is_write (fr_wr_r),
        .phy_addr (fr_phy_r),
        .reg_idx  (fr_reg_r),
        .wdata    (fr_data_r),
        .mdio_s   (mdio_i),
        .busy     (eng_busy),
        .done     (eng_done),
        .ack      (eng_ack),
        .rdata    (eng_rdata),
        .mdc      (mdc),
        .mdio_o   (mdio_o),
        .mdio_oe  (mdio_oe)
    );

endmodule // mdua_top
`default_nettype wire

/* verification/mdua_monitor.sv */
// port checker for the management access engine
`timescale 1ns/1ps
`default_nettype none
module mdua_monitor (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        mdc,
    input wire logic        mdio_o,
    input wire logic        mdio_oe,
    input wire logic        mdio_i,
    input wire logic        done_irq,
    input wire logic        link_irq
);
    logic [7:0] since_rise_r;
    wire        apb_wr = psel & penable & pwrite;
    // cycles since last mdc rise; saturates so reset never trips the period check
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            since_rise_r <= 8'hff;
        else if ($rose(mdc))
            since_rise_r <= 8'h01;
        else if (since_rise_r != 8'hff)
            since_rise_r <= since_rise_r + 8'h01;
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_ready_after_setup: assert property (psel && !penable |=> pready)
        else $error("pready missing after setup");
    a_ready_one_cycle: assert property (pready |=> !pready)
        else $error("pready held too long");
    a_err_with_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    a_idle_data_zero: assert property (!pready || pslverr |-> prdata == 32'h0000_0000)
        else $error("prdata not zero outside a good read");
    a_mdc_period_min: assert property ($rose(mdc) |-> since_rise_r >= 8'h28)
        else $error("mdc period below forty cycles");
    a_mdc_high_hold: assert property ($rose(mdc) |=> mdc [*8])
        else $error("mdc high phase too short");
    a_pin_change_low: assert property ($changed(mdio_o) || $changed(mdio_oe) |-> !mdc)
        else $error("data pin changed while mdc high");
    a_done_irq_clear: assert property ($fell(done_irq) |-> $past(apb_wr, 2))
        else $error("done_irq dropped without a write");
    a_link_irq_clear: assert property ($fell(link_irq) |-> $past(apb_wr, 2))
        else $error("link_irq dropped without a write");
endmodule // mdua_monitor

bind mdua_top mdua_monitor u_mon (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .mdc(mdc), .mdio_o(mdio_o), .mdio_oe(mdio_oe), .mdio_i(mdio_i), .done_irq(done_irq), .link_irq(link_irq));
`default_nettype wire

/* verification/mdua_phy_model.sv */
// behavioural phy on the management bus, answering at one address
`timescale 1ns/1ps
`default_nettype none
module mdua_phy_model #(
    parameter logic [4:0] PHY_ADDR = 5'h03
) (
    input  wire logic mdc,
    input  wire logic mdio,
    output var  logic phy_o,
    output var  logic phy_oe
);
    logic [15:0] regs [0:31];
    logic [15:0] sh;
    logic [4:0]  cnt;
    logic        act;
    logic        rd;
    logic        hit;
    logic [4:0]  ra;
    initial
    begin
        foreach (regs[i]) regs[i] = 16'h0000;
        regs[1] = 16'h0004; // status reports link up
        sh = 16'hffff;
        act = 1'b0;
        cnt = 5'h00;
        phy_o = 1'b1;
        phy_oe = 1'b0;
    end
    // decode start, opcode, address, index, data
    always @(posedge mdc)
    begin
        sh = {sh[14:0], mdio};
        if (!act && sh[1:0] == 2'b01)
        begin
            act = 1'b1;
            cnt = 5'h00;
        end
        else if (act)
        begin
            cnt = cnt + 5'h01;
            if (cnt == 5'h02) rd = (sh[1:0] == 2'b10);
            if (cnt == 5'h07) hit = (sh[4:0] == PHY_ADDR);
            if (cnt == 5'h0c) ra = sh[4:0];
            if (cnt == 5'h1e)
            begin
                if (!rd && hit) regs[ra] = sh;
                act = 1'b0;
                sh = 16'hffff; // stale data bits must not look like a start
            end
        end
    end
    // answer reads after the falling edge; otherwise release to the pull-up
    always @(negedge mdc)
    begin
        if (act && rd && hit && cnt == 5'h0d)
        begin
            phy_oe = 1'b1;
            phy_o = 1'b0; // acknowledge in turnaround
        end
        else if (act && rd && hit && cnt >= 5'h0e && cnt <= 5'h1d)
            phy_o = regs[ra][5'h1d - cnt]; // msb first
        else
        begin
            phy_oe = 1'b0;
            phy_o = 1'b1;
        end
    end
endmodule // mdua_phy_model
`default_nettype wire

/* verification/mdua_top_tb_top.sv */
// testbench: apb register sequences against the phy model
`timescale 1ns/1ps
`default_nettype none
`include "mdua_consts.vh"
module mdua_top_tb_top;
    localparam logic [4:0] PHYA = 5'h03;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] rd;
    logic        err;
    int          mismatches = 0;
    int          comparisons = 0;
    wire [31:0]  prdata;
    wire         pready, pslverr, mdc, mdio_o, mdio_oe, phy_o, phy_oe, done_irq, link_irq;
    // shared data wire with pull-up when nobody drives
    wire         mdio = mdio_oe ? mdio_o : (phy_oe ? phy_o : 1'b1);
    always #5 pclk = ~pclk;
    mdua_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .mdc(mdc),
        .mdio_o(mdio_o), .mdio_oe(mdio_oe), .mdio_i(mdio), .done_irq(done_irq), .link_irq(link_irq));
    mdua_phy_model #(.PHY_ADDR(PHYA)) u_phy (.mdc(mdc), .mdio(mdio), .phy_o(phy_o), .phy_oe(phy_oe));
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // one apb transfer; request held until pready is seen at an edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1)
        begin
            mismatches++;
            report_and_stop();
        end
    endtask
    // poll the pending flag under a bound
    task automatic wait_idle(input logic [7:0] a);
        int n;
        n = 0;
        do
        begin
            apb(1'b0, a, 32'h0000_0000);
            n++;
        end
        while (rd[31] !== 1'b0 && n < 3000);
        if (rd[31] !== 1'b0)
        begin
            mismatches++;
            report_and_stop();
        end
    endtask
    initial
    begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, `MDUA_OFF_CONTROL, 32'h0000_0000);
        check("control reset", rd, 32'h8000_00ff);
        apb(1'b0, 8'h40, 32'h0000_0000);
        check("unmapped", {rd[30:0], err}, 32'h0000_0001);
        apb(1'b1, `MDUA_OFF_MASK_SET, 32'h0000_0001);
        apb(1'b1, `MDUA_OFF_ACCESS0, {2'b11, 4'h0, 5'h04, PHYA, 16'ha5c3});
        repeat (100) @(posedge pclk);
        apb(1'b0, `MDUA_OFF_ACCESS0, 32'h0000_0000);
        check("held while off", {31'h0000_0000, rd[31]}, 32'h0000_0001);
        apb(1'b1, `MDUA_OFF_CONTROL, 32'h4010_0000);
        wait_idle(`MDUA_OFF_ACCESS0);
        apb(1'b0, `MDUA_OFF_DONE_RAW, 32'h0000_0000);
        check("raw after write", rd, 32'h0000_0001);
        check("done irq", {31'h0000_0000, done_irq}, 32'h0000_0001);
        apb(1'b0, `MDUA_OFF_DONE_MASKED, 32'h0000_0000);
        check("masked", rd, 32'h0000_0001);
        apb(1'b1, `MDUA_OFF_DONE_RAW, 32'h0000_0001);
        apb(1'b1, `MDUA_OFF_ACCESS1, {2'b10, 4'h0, 5'h04, PHYA, 16'h0000});
        wait_idle(`MDUA_OFF_ACCESS1);
        check("read back", rd, {2'b00, 1'b1, 3'h0, 5'h04, PHYA, 16'ha5c3});
        apb(1'b0, `MDUA_OFF_DONE_RAW, 32'h0000_0000);
        check("raw channel1", rd, 32'h0000_0002);
        check("irq masked off", {31'h0000_0000, done_irq}, 32'h0000_0000);
        apb(1'b1, `MDUA_OFF_ACCESS0, {2'b10, 4'h0, 5'h04, 5'h09, 16'h0000});
        wait_idle(`MDUA_OFF_ACCESS0);
        check("absent ack", {31'h0000_0000, rd[29]}, 32'h0000_0000);
        apb(1'b0, `MDUA_OFF_ALIVE, 32'h0000_0000);
        check("alive", rd, 32'h0000_0001 << PHYA);
        apb(1'b1, `MDUA_OFF_SELECT0, 32'h0000_0080 | PHYA);
        for (int i = 0; i < 8000 && link_irq !== 1'b1; i++)
            @(posedge pclk);
        if (link_irq !== 1'b1)
        begin
            mismatches++;
            report_and_stop();
        end
        apb(1'b0, `MDUA_OFF_LINK, 32'h0000_0000);
        check("link", rd, 32'h0000_0001 << PHYA);
        apb(1'b1, `MDUA_OFF_LINK_CHG, 32'h0000_0001);
        apb(1'b0, `MDUA_OFF_LINK_CHG, 32'h0000_0000);
        check("link change cleared", {rd[30:0], link_irq}, 32'h0000_0000);
        apb(1'b1, `MDUA_OFF_DONE_RAW, 32'h0000_0003);
        apb(1'b1, `MDUA_OFF_ACCESS0, {2'b11, 4'h0, 5'h05, PHYA, 16'h1234});
        apb(1'b1, `MDUA_OFF_ACCESS1, {2'b11, 4'h0, 5'h06, PHYA, 16'h5678});
        wait_idle(`MDUA_OFF_ACCESS0);
        wait_idle(`MDUA_OFF_ACCESS1);
        apb(1'b0, `MDUA_OFF_DONE_RAW, 32'h0000_0000);
        check("both served", rd, 32'h0000_0003);
        apb(1'b1, `MDUA_OFF_CONTROL, 32'h4000_0000);
        apb(1'b1, `MDUA_OFF_ACCESS1, {2'b10, 4'h0, 5'h05, PHYA, 16'h0000});
        wait_idle(`MDUA_OFF_ACCESS1);
        check("preamble read", rd, {2'b00, 1'b1, 3'h0, 5'h05, PHYA, 16'h1234});
        apb(1'b0, `MDUA_OFF_ALIVE, 32'h0000_0000);
        check("alive again", rd, 32'h0000_0001 << PHYA);
        report_and_stop();
    end
endmodule // mdua_top_tb_top
`default_nettype wire
